// *** logic/fpc_pkg.sv ***
// Constants and types for the flash program/erase parameter checker
// Overview of operation
// - Before an erase the key register is compared with 8'h5a and bit 4 is set on mismatch, cleared on match.
// - The erase block number must lie inside the memory array's block range, else bit 3 is set.
// - Bits 2 and 1 of the erase result byte always read as zero.
// - Bit 0 of the erase result byte is 0 for a clean erase and 1 for an abnormal end.
// - A destination address outside the flash area raises the write-address error.
// - A destination address not on a 128-byte boundary raises the write-address error.
// - Each program operation writes one contiguous 128-byte unit starting at the destination address.
// - Bit 6 is set when the flash is in its error protection state at erase start or during the erase, and is cleared at an erase start without it.
// - Bit 5 is set when the array could not be erased or flash settings changed mid-operation.
package fpc_pkg;

    localparam logic [7:0]  KEY_VALUE        = 8'h5a;
    localparam int          BIT_MODE_ERR     = 6;
    localparam int          BIT_EXEC_ERR     = 5;
    localparam int          BIT_KEY_ERR      = 4;
    localparam int          BIT_BLOCK_ERR    = 3;
    localparam int          BIT_PASS_FAIL    = 0;
    localparam logic [7:0]  STATUS_RESET     = 8'h00;
    localparam logic [15:0] FREQ_MIN_CODE    = 16'h0320;
    localparam logic [15:0] FREQ_MAX_CODE    = 16'h0dac;
    localparam logic [31:0] PROG_UNIT_BYTES  = 32'h0000_0080;
    localparam int          PROG_ALIGN_BITS  = 7;
    localparam logic [31:0] ADDR_RESET       = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ERASE_WAIT,
        ST_PROG_WAIT
    } fpc_state_t;

    typedef struct packed {
        logic       unused7;
        logic       mode_error_flag;
        logic       erase_execution_error_flag;
        logic       key_error_flag;
        logic       block_select_error_flag;
        logic [1:0] unused21;
        logic       pass_fail_flag;
    } fpc_erase_status_t;

    typedef struct packed {
        logic key_error;
        logic block_error;
        logic addr_error;
        logic freq_ok;
    } fpc_check_t;

endpackage

// *** logic/fpc_param_check.sv ***
// Combinational parameter checks for erase and program requests
`timescale 1ns/1ns
module fpc_param_check #(
    parameter logic [31:0] NUM_BLOCKS  = 32'h0000_0014,
    parameter logic [31:0] FLASH_BASE  = 32'h0000_0000,
    parameter logic [31:0] FLASH_BYTES = 32'h0010_0000
) (
    input  wire logic [7:0]          flash_key_register,
    input  wire logic [31:0]         erase_block_number,
    input  wire logic [31:0]         operating_frequency_param,
    input  wire logic [31:0]         program_destination_address,
    output fpc_pkg::fpc_check_t      check
);

    logic [31:0] last_unit;
    logic        out_of_area;
    logic        misaligned;

    assign last_unit = FLASH_BASE + FLASH_BYTES - fpc_pkg::PROG_UNIT_BYTES;

    assign check.key_error = (flash_key_register != fpc_pkg::KEY_VALUE);
    assign check.block_error = (erase_block_number >= NUM_BLOCKS);
    assign out_of_area = (program_destination_address < FLASH_BASE) ||
                         (program_destination_address > last_unit);
    assign misaligned = |program_destination_address[fpc_pkg::PROG_ALIGN_BITS-1:0];
    assign check.addr_error = out_of_area | misaligned;
    // Informational only, software owns the window
    assign check.freq_ok = (operating_frequency_param[31:16] == 16'h0000) &&
                           (operating_frequency_param[15:0] >= fpc_pkg::FREQ_MIN_CODE) &&
                           (operating_frequency_param[15:0] <= fpc_pkg::FREQ_MAX_CODE);

endmodule // fpc_param_check

// *** logic/fpc_top.sv ***
// Flash program/erase sequencer with parameter checks and result reporting
`timescale 1ns/1ns
module fpc_top #(
    parameter logic [31:0] NUM_BLOCKS  = 32'h0000_0014,
    parameter logic [31:0] FLASH_BASE  = 32'h0000_0000,
    parameter logic [31:0] FLASH_BYTES = 32'h0010_0000
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        erase_start,
    input  wire logic        program_start,
    input  wire logic [7:0]  flash_key_register,
    input  wire logic [31:0] erase_block_number,
    input  wire logic [31:0] operating_frequency_param,
    input  wire logic [31:0] program_destination_address,
    input  wire logic        error_protection_state,
    input  wire logic        settings_changed,
    input  wire logic        array_done,
    input  wire logic        array_fail,
    output logic [7:0]       erase_result_status,
    output logic             write_address_error_flag,
    output logic             program_fail_flag,
    output logic             frequency_ok,
    output logic             erase_req,
    output logic [31:0]      erase_block,
    output logic             program_req,
    output logic [31:0]      program_unit_address,
    output logic             busy,
    output logic             op_done
);

    typedef struct packed {
        fpc_pkg::fpc_state_t        state;
        fpc_pkg::fpc_erase_status_t status;
        logic                       addr_err;
        logic                       prog_fail;
        logic                       freq_ok;
        logic                       erase_req;
        logic [31:0]                block;
        logic                       prog_req;
        logic [31:0]                prog_addr;
        logic                       busy;
        logic                       done;
    } fpc_regs_t;

    fpc_regs_t           state_reg;
    fpc_regs_t           state_next;
    fpc_pkg::fpc_check_t check;

    // Checks are combinational; results are sampled at the taking edge
    fpc_param_check #(
        .NUM_BLOCKS  (NUM_BLOCKS),
        .FLASH_BASE  (FLASH_BASE),
        .FLASH_BYTES (FLASH_BYTES)
    ) u_check (
        .flash_key_register          (flash_key_register),
        .erase_block_number          (erase_block_number),
        .operating_frequency_param   (operating_frequency_param),
        .program_destination_address (program_destination_address),
        .check                       (check)
    );

    // Checks that skip the array, per kind of request
    function automatic logic start_refused(
        input logic                prot,
        input fpc_pkg::fpc_check_t chk,
        input logic                is_erase
    );
        if (is_erase)
        begin
            return prot | chk.key_error | chk.block_error;
        end
        return prot | chk.addr_error;
    endfunction

    // Array failure or register disturbance ends the operation in error
    function automatic logic exec_fault(
        input logic changed,
        input logic done,
        input logic fail
    );
        return changed | (done & fail);
    endfunction

    always_comb
    begin
        state_next      = state_reg;
        // Done is a one-cycle pulse
        state_next.done = 1'b0;
        unique case (state_reg.state)
            fpc_pkg::ST_IDLE:
            begin
                // Starts while busy are ignored; erase wins over program
                if (erase_start)
                begin
                    state_next.freq_ok = check.freq_ok;
                    state_next.status.mode_error_flag = error_protection_state;
                    state_next.status.key_error_flag = check.key_error;
                    state_next.status.block_select_error_flag = check.block_error;
                    state_next.status.erase_execution_error_flag = 1'b0;
                    if (start_refused(error_protection_state, check, 1'b1))
                    begin
                        state_next.status.pass_fail_flag = 1'b1;
                        state_next.done                  = 1'b1;
                    end
                    else
                    begin
                        state_next.status.pass_fail_flag = 1'b0;
                        state_next.erase_req             = 1'b1;
                        state_next.block                 = erase_block_number;
                        state_next.busy                  = 1'b1;
                        state_next.state                 = fpc_pkg::ST_ERASE_WAIT;
                    end
                end
                else if (program_start)
                begin
                    state_next.freq_ok = check.freq_ok;
                    state_next.addr_err = check.addr_error;
                    if (start_refused(error_protection_state, check, 1'b0))
                    begin
                        state_next.prog_fail = 1'b1;
                        state_next.done      = 1'b1;
                    end
                    else
                    begin
                        state_next.prog_fail = 1'b0;
                        state_next.prog_req  = 1'b1;
                        state_next.prog_addr = program_destination_address;
                        state_next.busy      = 1'b1;
                        state_next.state     = fpc_pkg::ST_PROG_WAIT;
                    end
                end
            end
            fpc_pkg::ST_ERASE_WAIT:
            begin
                if (exec_fault(settings_changed, array_done, array_fail))
                begin
                    state_next.status.erase_execution_error_flag = 1'b1;
                end
                // Protection seen mid-erase still marks the mode error
                if (error_protection_state)
                begin
                    state_next.status.mode_error_flag = 1'b1;
                end
                if (array_done)
                begin
                    state_next.status.pass_fail_flag =
                        state_next.status.erase_execution_error_flag |
                        state_next.status.mode_error_flag;
                    state_next.erase_req = 1'b0;
                    state_next.busy      = 1'b0;
                    state_next.done      = 1'b1;
                    state_next.state     = fpc_pkg::ST_IDLE;
                end
            end
            fpc_pkg::ST_PROG_WAIT:
            begin
                // Program shares the array fault path with erase
                if (exec_fault(settings_changed, array_done, array_fail))
                begin
                    state_next.prog_fail = 1'b1;
                end
                if (array_done)
                begin
                    state_next.prog_req = 1'b0;
                    state_next.busy     = 1'b0;
                    state_next.done     = 1'b1;
                    state_next.state    = fpc_pkg::ST_IDLE;
                end
            end
            default:
            begin
                state_next.state = fpc_pkg::ST_IDLE;
            end
        endcase
        state_next.status.unused7  = 1'b0;
        state_next.status.unused21 = 2'b00;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state_reg.state     <= fpc_pkg::ST_IDLE;
            state_reg.status    <= fpc_pkg::STATUS_RESET;
            state_reg.addr_err  <= 1'b0;
            state_reg.prog_fail <= 1'b0;
            state_reg.freq_ok   <= 1'b0;
            state_reg.erase_req <= 1'b0;
            state_reg.block     <= fpc_pkg::ADDR_RESET;
            state_reg.prog_req  <= 1'b0;
            state_reg.prog_addr <= fpc_pkg::ADDR_RESET;
            state_reg.busy      <= 1'b0;
            state_reg.done      <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Outputs are plain register taps
    assign erase_result_status      = state_reg.status;
    assign write_address_error_flag = state_reg.addr_err;
    assign program_fail_flag        = state_reg.prog_fail;
    assign frequency_ok             = state_reg.freq_ok;
    assign erase_req                = state_reg.erase_req;
    assign erase_block              = state_reg.block;
    assign program_req              = state_reg.prog_req;
    assign program_unit_address     = state_reg.prog_addr;
    assign busy                     = state_reg.busy;
    assign op_done                  = state_reg.done;

endmodule // fpc_top

// *** tb/fpc_assertions.sv ***
// Assertion checker bound to the flash parameter checker top
`timescale 1ns/1ns
module fpc_chk #(
    parameter logic [31:0] NUM_BLOCKS = 32'h0000_0014
) (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        erase_start,
    input wire logic        program_start,
    input wire logic [7:0]  flash_key_register,
    input wire logic [31:0] erase_block_number,
    input wire logic [31:0] program_destination_address,
    input wire logic [7:0]  erase_result_status,
    input wire logic        write_address_error_flag,
    input wire logic        erase_req,
    input wire logic        program_req,
    input wire logic [31:0] program_unit_address,
    input wire logic        busy,
    input wire logic        op_done
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // Idle starts only; erase wins when both are raised
    wire       es = erase_start && !busy;
    wire       ps = program_start && !erase_start && !busy;
    wire [7:0] st = erase_result_status;

    property p_key; es && flash_key_register != 8'h5a |=> st[4] && st[0] && op_done && !erase_req;
    endproperty
    a_key: assert property (p_key) else $error("key error not reported");
    property p_key_ok; es && flash_key_register == 8'h5a |=> !st[4]; endproperty
    a_key_ok: assert property (p_key_ok) else $error("key error on good key");
    property p_blk; es && erase_block_number >= NUM_BLOCKS |=> st[3] && st[0] && !erase_req;
    endproperty
    a_blk: assert property (p_blk) else $error("block error not reported");
    property p_blk_ok; es && erase_block_number < NUM_BLOCKS |=> !st[3]; endproperty
    a_blk_ok: assert property (p_blk_ok) else $error("block error on valid block");
    property p_zero; st[2:1] == 2'h0 && !st[7]; endproperty
    a_zero: assert property (p_zero) else $error("unused status bits not zero");
    property p_sf; $fell(erase_req) |-> st[0] == (st[5] || st[6]); endproperty
    a_sf: assert property (p_sf) else $error("pass fail bit wrong at erase end");
    property p_wa; ps && program_destination_address[6:0] != 7'h00
        |=> write_address_error_flag && !program_req; endproperty
    a_wa: assert property (p_wa) else $error("misaligned address accepted");
    property p_unit; $rose(program_req) |-> program_unit_address[6:0] == 7'h00
        && program_unit_address == $past(program_destination_address); endproperty
    a_unit: assert property (p_unit) else $error("unit address not captured");
    c_erase: cover property ($fell(erase_req) && !st[0]);
    c_prog: cover property ($fell(program_req));
    c_wa: cover property (ps && program_destination_address[6:0] != 7'h00);
endmodule // fpc_chk

bind fpc_top fpc_chk #(.NUM_BLOCKS(NUM_BLOCKS)) u_chk (
    .mclk(mclk), .reset(reset), .erase_start(erase_start), .program_start(program_start),
    .flash_key_register(flash_key_register), .erase_block_number(erase_block_number),
    .program_destination_address(program_destination_address),
    .erase_result_status(erase_result_status),
    .write_address_error_flag(write_address_error_flag), .erase_req(erase_req),
    .program_req(program_req), .program_unit_address(program_unit_address),
    .busy(busy), .op_done(op_done));

// *** tb/fpc_top_tb.sv ***
// Self-checking bench for the flash parameter checker top
`timescale 1ns/1ns
module fpc_top_tb;
    logic        mclk = 1'h0, reset = 1'h1, erase_start = 1'h0, program_start = 1'h0;
    logic        error_protection_state = 1'h0, fail_mode = 1'h0;
    // Array answer and settings disturbance, driven by the bench
    logic        settings_changed = 1'h0, array_done = 1'h0, array_fail = 1'h0;
    logic [7:0]  flash_key_register = 8'h00;
    logic [31:0] erase_block_number = 32'h0000_0000, operating_frequency_param = 32'h0000_0dac;
    logic [31:0] program_destination_address = 32'h0000_0000;
    logic [7:0]  erase_result_status;
    logic [31:0] erase_block, program_unit_address;
    logic        write_address_error_flag, program_fail_flag, frequency_ok;
    logic        erase_req, program_req, busy, op_done;
    int          fails = 0, comparisons = 0;

    fpc_top uut (
        .mclk(mclk), .reset(reset), .erase_start(erase_start), .program_start(program_start),
        .flash_key_register(flash_key_register), .erase_block_number(erase_block_number),
        .operating_frequency_param(operating_frequency_param),
        .program_destination_address(program_destination_address),
        .error_protection_state(error_protection_state), .settings_changed(settings_changed),
        .array_done(array_done), .array_fail(array_fail),
        .erase_result_status(erase_result_status),
        .write_address_error_flag(write_address_error_flag),
        .program_fail_flag(program_fail_flag), .frequency_ok(frequency_ok),
        .erase_req(erase_req), .erase_block(erase_block), .program_req(program_req),
        .program_unit_address(program_unit_address), .busy(busy), .op_done(op_done));

    initial
    begin
        forever #25 mclk = ~mclk;
    end

    // Array answers one cycle after it sees busy
    always @(posedge mclk)
    begin
        array_done <= busy === 1'h1 && !array_done;
        array_fail <= fail_mode;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic go(input logic er, input logic run);
        int n;
        erase_start <= er;
        program_start <= !er;
        @(posedge mclk);
        erase_start <= 1'h0;
        program_start <= 1'h0;
        #1;
        chk("busy", 32'(run), 32'(busy));
        chk("request", 32'(run), 32'(er ? erase_req : program_req));
        for (n = 0; n < 20 && op_done !== 1'h1; n++)
        begin
            @(posedge mclk);
            #1;
        end
        chk("op_done", 32'h0000_0001, 32'(op_done));
    endtask

    task automatic e_op(input logic [7:0] key, input logic [31:0] blk, input logic prot,
                        input logic fl, input logic [7:0] exp);
        @(posedge mclk);
        flash_key_register <= key;
        erase_block_number <= blk;
        error_protection_state <= prot;
        fail_mode <= fl;
        go(1'h1, key == 8'h5a && blk < 32'h0000_0014 && prot == 1'h0);
        chk("erase_result_status", 32'(exp), 32'(erase_result_status));
    endtask

    task automatic p_op(input logic [31:0] addr, input logic [31:0] freq, input logic wa,
                        input logic fok);
        @(posedge mclk);
        program_destination_address <= addr;
        operating_frequency_param <= freq;
        error_protection_state <= 1'h0;
        fail_mode <= 1'h0;
        go(1'h0, !wa);
        chk("write_address_error_flag", 32'(wa), 32'(write_address_error_flag));
        chk("program_fail_flag", 32'(wa), 32'(program_fail_flag));
        chk("frequency_ok", 32'(fok), 32'(frequency_ok));
        if (wa === 1'h0) chk("program_unit_address", addr, program_unit_address);
    endtask

    task automatic t_erase;
        e_op(8'h5a, 32'h0000_0003, 1'h0, 1'h0, 8'h00);
        chk("erase_block", 32'h0000_0003, erase_block);
        e_op(8'h00, 32'h0000_0003, 1'h0, 1'h0, 8'h11);
        e_op(8'h5a, 32'h0000_0013, 1'h0, 1'h0, 8'h00);
        e_op(8'h5a, 32'h0000_0014, 1'h0, 1'h0, 8'h09);
        e_op(8'ha5, 32'h0000_0014, 1'h0, 1'h0, 8'h19);
        e_op(8'h5a, 32'h0000_0003, 1'h1, 1'h0, 8'h41);
        e_op(8'h5a, 32'h0000_0003, 1'h0, 1'h1, 8'h21);
        @(posedge mclk);
        settings_changed <= 1'h1;
        e_op(8'h5a, 32'h0000_0003, 1'h0, 1'h0, 8'h21);
        @(posedge mclk);
        settings_changed <= 1'h0;
    endtask

    task automatic t_prog;
        p_op(32'h0000_0080, 32'h0000_0dac, 1'h0, 1'h1);
        p_op(32'h0000_0040, 32'h0000_0320, 1'h1, 1'h1);
        p_op(32'h0010_0000, 32'h0000_0dad, 1'h1, 1'h0);
        p_op(32'h000f_ff80, 32'h0001_0320, 1'h0, 1'h0);
        p_op(32'h0000_0100, 32'h0000_031f, 1'h0, 1'h0);
        p_op(32'h0000_0180, 32'h0000_0d05, 1'h0, 1'h1);
        p_op(32'h0000_0200, 32'h0000_09c4, 1'h0, 1'h1);
        p_op(32'h0000_0280, 32'h0000_0dac, 1'h0, 1'h1);
    endtask

    task automatic close_out;
        if (fails == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(posedge mclk);
        reset <= 1'h0;
        @(posedge mclk);
        #1;
        chk("erase_result_status", 32'h0000_0000, 32'(erase_result_status));
        t_erase();
        t_prog();
        close_out();
    end

    // Whole run needs about 60 cycles
    initial
    begin
        repeat (2000) @(posedge mclk);
        fails++;
        close_out();
    end
endmodule // fpc_top_tb
